// [hdl/pkc_pad_keeper_control.sv]
// Pad keeper control register with classic Wishbone slave and pad enables
//
// Behaviour
// - Bit 7 clear enables both debug pin pull-ups; set disables them; reset 0.
// - Bit 6 clear enables scan port pull-ups and pull-down; set disables; reset 0.
// - Bit 5 clear enables interrupt/watchdog pin pull-up; set disables; reset 0.
// - Bit 4 controls host control pins: pin 1 pull-down, others pull-up.
// - Bit 3 clear enables holders on eight host data pins; reset 0.
// - Bit 2 controls sixteen memory control keepers; pins 3, 14 pull-ups.
// - Bit 1 clear enables holders on 32 memory data pins; reset 0.
// - Bit 0 clear enables holders on memory address pins 21..2; reset 0.
// - Keeper enables follow control bits regardless of pin function.
`include "pkc_defs.svh"
`default_nettype none

module pkc_pad_keeper_control
   import pkc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   // Classic Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [`PKC_ADDR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic wb_err_o,
   // Active-high pad keeper enables
   output logic [1:0] debug_pullup_en_o,
   output logic [2:0] scan_pullup_en_o,
   output logic scan_pulldown_en_o,
   output logic watchdog_pullup_en_o,
   output logic [`PKC_HCTRL_W-1:0] host_ctrl_pullup_en_o,
   output logic [`PKC_HCTRL_W-1:0] host_ctrl_pulldown_en_o,
   output logic [`PKC_HDATA_W-1:0] host_data_holder_en_o,
   output logic [`PKC_MCTRL_W-1:0] mem_ctrl_pullup_en_o,
   output logic [`PKC_MCTRL_W-1:0] mem_ctrl_holder_en_o,
   output logic [`PKC_MDATA_W-1:0] mem_data_holder_en_o,
   output logic [`PKC_MADDR_W-1:0] mem_addr_holder_en_o
);

   // ****************************************************************
   // Functions
   // ****************************************************************

   // Widen a stored disable bit into an active-high enable vector
   function automatic logic [31:0] pkc_enable(input logic dis);
      pkc_enable = dis ? 32'h00000000 : 32'hFFFFFFFF;
   endfunction

   // ****************************************************************
   // Bus decode
   // ****************************************************************

   pkc_ctrl_t ctrl_r;
   pkc_ctrl_t ctrl_nxt;
   pkc_state_t state_r;
   logic [31:0] rdata_nxt;
   logic [31:0] dat_r;
   logic ack_r;
   logic err_r;

   wire logic req_w = wb_cyc_i & wb_stb_i & (state_r == PKC_IDLE);
   wire logic hit_ctrl_w = (wb_adr_i == `PKC_CTRL_OFFSET);
   wire logic hit_id_w = (wb_adr_i == `PKC_ID_OFFSET);
   wire logic hit_w = hit_ctrl_w | hit_id_w;
   // Only byte lane 0 holds writable bits; upper lanes are dropped
   wire logic wr_ctrl_w = req_w & wb_we_i & hit_ctrl_w & wb_sel_i[0];

   // Next control value; reserved bits 31..8 have no storage at all
   assign ctrl_nxt = wr_ctrl_w ? wb_dat_i[7:0] : ctrl_r;

   // Read data: control byte in low bits with upper bits zero, or the ID word
   assign rdata_nxt = hit_ctrl_w ? {24'h000000, ctrl_r} :
                      hit_id_w ? `PKC_ID_VALUE : 32'h00000000;

   // ****************************************************************
   // Registers
   // ****************************************************************

   // Control byte, all groups enabled at reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_r <= `PKC_CTRL_RESET;
      end else begin
         ctrl_r <= ctrl_nxt;
      end
   end

   // Single-cycle answer; ack drops the cycle after so the master can release
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r <= PKC_IDLE;
         ack_r <= 1'b0;
         err_r <= 1'b0;
         dat_r <= 32'h00000000;
      end else begin
         unique case (state_r)
            PKC_IDLE: begin
               ack_r <= req_w & hit_w;
               err_r <= req_w & ~hit_w; // Unmapped address answered with err
               dat_r <= (req_w & ~wb_we_i) ? rdata_nxt : 32'h00000000;
               state_r <= req_w ? PKC_ACK : PKC_IDLE;
            end
            PKC_ACK: begin
               ack_r <= 1'b0;
               err_r <= 1'b0;
               dat_r <= 32'h00000000;
               state_r <= PKC_IDLE;
            end
         endcase
      end
   end

   assign wb_ack_o = ack_r;
   assign wb_err_o = err_r;
   assign wb_dat_o = dat_r;

   // ****************************************************************
   // Pad enables
   // ****************************************************************

   // Registered enables; they ignore pin function muxing entirely
   logic [1:0] dbg_r;
   logic [2:0] scu_r;
   logic scd_r;
   logic wdg_r;
   logic [`PKC_HCTRL_W-1:0] hcu_r;
   logic [`PKC_HCTRL_W-1:0] hcd_r;
   logic [`PKC_HDATA_W-1:0] hd_r;
   logic [`PKC_MCTRL_W-1:0] mcu_r;
   logic [`PKC_MCTRL_W-1:0] mch_r;
   logic [`PKC_MDATA_W-1:0] md_r;
   logic [`PKC_MADDR_W-1:0] ma_r;

   // Host control: one pull-down pin, the rest pull-ups
   wire logic [`PKC_HCTRL_W-1:0] hc_pd_mask_w = `PKC_HCTRL_W'(1) << `PKC_HCTRL_PD_PIN;
   // Memory control: two pull-up pins, the rest holders
   wire logic [`PKC_MCTRL_W-1:0] mc_pu_mask_w =
      (`PKC_MCTRL_W'(1) << `PKC_MCTRL_PU_A) | (`PKC_MCTRL_W'(1) << `PKC_MCTRL_PU_B);

   wire logic [31:0] hc_en_w = pkc_enable(ctrl_r[`PKC_BIT_HCTRL]);
   wire logic [31:0] mc_en_w = pkc_enable(ctrl_r[`PKC_BIT_MCTRL]);

   // Enables are driven from the stored bits, one cycle after a write lands
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dbg_r <= 2'h3;
         scu_r <= 3'h7;
         scd_r <= 1'b1;
         wdg_r <= 1'b1;
         hcu_r <= ~hc_pd_mask_w;
         hcd_r <= hc_pd_mask_w;
         hd_r <= {`PKC_HDATA_W{1'b1}};
         mcu_r <= mc_pu_mask_w;
         mch_r <= ~mc_pu_mask_w;
         md_r <= {`PKC_MDATA_W{1'b1}};
         ma_r <= {`PKC_MADDR_W{1'b1}};
      end else begin
         dbg_r <= {2{~ctrl_r[`PKC_BIT_DEBUG]}};
         scu_r <= {3{~ctrl_r[`PKC_BIT_SCAN]}};
         scd_r <= ~ctrl_r[`PKC_BIT_SCAN];
         wdg_r <= ~ctrl_r[`PKC_BIT_WDOG];
         hcu_r <= hc_en_w[`PKC_HCTRL_W-1:0] & ~hc_pd_mask_w;
         hcd_r <= hc_en_w[`PKC_HCTRL_W-1:0] & hc_pd_mask_w;
         hd_r <= {`PKC_HDATA_W{~ctrl_r[`PKC_BIT_HDATA]}};
         mcu_r <= mc_en_w[`PKC_MCTRL_W-1:0] & mc_pu_mask_w;
         mch_r <= mc_en_w[`PKC_MCTRL_W-1:0] & ~mc_pu_mask_w;
         md_r <= {`PKC_MDATA_W{~ctrl_r[`PKC_BIT_MDATA]}};
         ma_r <= {`PKC_MADDR_W{~ctrl_r[`PKC_BIT_MADDR]}};
      end
   end

   assign debug_pullup_en_o = dbg_r;
   assign scan_pullup_en_o = scu_r;
   assign scan_pulldown_en_o = scd_r;
   assign watchdog_pullup_en_o = wdg_r;
   assign host_ctrl_pullup_en_o = hcu_r;
   assign host_ctrl_pulldown_en_o = hcd_r;
   assign host_data_holder_en_o = hd_r;
   assign mem_ctrl_pullup_en_o = mcu_r;
   assign mem_ctrl_holder_en_o = mch_r;
   assign mem_data_holder_en_o = md_r;
   assign mem_addr_holder_en_o = ma_r;

endmodule // pkc_pad_keeper_control
`default_nettype wire

// [hdl/pkc_defs.svh]
// Constants for the pad keeper control register block
`ifndef PKC_DEFS_SVH
`define PKC_DEFS_SVH

// Register map (byte address within the block)
`define PKC_ADDR_W 4
`define PKC_CTRL_OFFSET 4'h0
`define PKC_ID_OFFSET 4'h4

// Control register layout
`define PKC_CTRL_RESET 8'h00
`define PKC_BIT_DEBUG 7
`define PKC_BIT_SCAN 6
`define PKC_BIT_WDOG 5
`define PKC_BIT_HCTRL 4
`define PKC_BIT_HDATA 3
`define PKC_BIT_MCTRL 2
`define PKC_BIT_MDATA 1
`define PKC_BIT_MADDR 0

// Pin group widths and pull pin indices
`define PKC_HCTRL_W 10
`define PKC_HCTRL_PD_PIN 1
`define PKC_HDATA_W 8
`define PKC_MCTRL_W 16
`define PKC_MCTRL_PU_A 3
`define PKC_MCTRL_PU_B 14
`define PKC_MDATA_W 32
`define PKC_MADDR_W 20

// Block identity word (value is arbitrary)
`define PKC_ID_VALUE 32'h00005A01

`endif

// [hdl/pkc_pkg.sv]
// Types for the pad keeper control register block
`default_nettype none
package pkc_pkg;
   typedef logic [7:0] pkc_ctrl_t;
   typedef enum logic {PKC_IDLE, PKC_ACK} pkc_state_t;
endpackage
`default_nettype wire

// [bench/pkc_keeper_props.sv]
// Assertions for the pad keeper control register block
`include "pkc_defs.svh"
`default_nettype none
module pkc_keeper_props (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [`PKC_ADDR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic wb_err_o,
   input wire logic [1:0] debug_pullup_en_o,
   input wire logic [19:0] mem_addr_holder_en_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Request taken only while the slave is idle, so held requests are not counted twice
   wire req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   wire wr0 = req && wb_we_i && wb_adr_i == `PKC_CTRL_OFFSET && wb_sel_i[0];
   wire unm = wb_adr_i != `PKC_CTRL_OFFSET && wb_adr_i != `PKC_ID_OFFSET;
   a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held too long");
   a_ack_after_req: assert property (req && !unm |=> wb_ack_o && !wb_err_o)
      else $error("no ack for mapped request");
   a_err_unmapped: assert property (req && unm |=> wb_err_o && !wb_ack_o)
      else $error("no error for unmapped request");
   a_debug_follow: assert property (wr0 |=> ##1 debug_pullup_en_o == {2{!$past(wb_dat_i[7], 2)}})
      else $error("debug pull-ups wrong after write");
   a_addr_follow: assert property (wr0 |=> ##1 mem_addr_holder_en_o == {20{!$past(wb_dat_i[0], 2)}})
      else $error("address holders wrong after write");
   a_read_reserved: assert property (req && !wb_we_i && !unm && wb_adr_i == `PKC_CTRL_OFFSET |=> wb_dat_o[31:8] == 24'h0)
      else $error("reserved bits read nonzero");
   a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside ack");
   a_reset_enabled: assert property ($fell(rst_i) |-> debug_pullup_en_o == 2'h3 && mem_addr_holder_en_o == 20'hFFFFF)
      else $error("keepers not enabled after reset");
endmodule // pkc_keeper_props
bind pkc_pad_keeper_control pkc_keeper_props i_props (.clk_i(clk_i), .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .wb_err_o(wb_err_o), .debug_pullup_en_o(debug_pullup_en_o),
   .mem_addr_holder_en_o(mem_addr_holder_en_o));
`default_nettype wire

// [bench/test_pad_keeper_control.sv]
// Self-checking testbench for the pad keeper control register block
`include "pkc_defs.svh"
`default_nettype none
module test_pad_keeper_control import pkc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, err, e;
   logic [3:0] adr = 4'h0, sel = 4'h0;
   logic [31:0] dat = 32'h0, dat_o, q, rnd, v;
   logic [118:0] pads;
   int fail_count = 0, check_count = 0;
   pkc_pad_keeper_control i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
      .wb_ack_o(ack), .wb_err_o(err), .debug_pullup_en_o(pads[118:117]),
      .scan_pullup_en_o(pads[116:114]), .scan_pulldown_en_o(pads[113]),
      .watchdog_pullup_en_o(pads[112]), .host_ctrl_pullup_en_o(pads[111:102]),
      .host_ctrl_pulldown_en_o(pads[101:92]), .host_data_holder_en_o(pads[91:84]),
      .mem_ctrl_pullup_en_o(pads[83:68]), .mem_ctrl_holder_en_o(pads[67:52]),
      .mem_data_holder_en_o(pads[51:20]), .mem_addr_holder_en_o(pads[19:0]));
   // 40 MHz clock
   always #12.5 clk_i = ~clk_i;
   // ****************
   // Models and tasks
   // ****************
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Every keeper enable is the inverse of its bit; host control pull-down on pin 1 only
   function automatic logic [118:0] exp_pads(input logic [7:0] c);
      return {{2{~c[7]}}, {4{~c[6]}}, ~c[5], {10{~c[4]}} & 10'h3FD, {10{~c[4]}} & 10'h002,
         {8{~c[3]}}, {16{~c[2]}} & 16'h4008, {16{~c[2]}} & 16'hBFF7, {32{~c[1]}}, {20{~c[0]}}};
   endfunction
   task automatic chk(input string nm, input logic [118:0] seen, input logic [118:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Classic cycle: hold until ack or err, bounded so a dead slave cannot hang us
   task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s, input logic [31:0] d);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= s;
      dat <= d;
      do begin @(posedge clk_i); n++; end while (!(ack | err) && n < 40);
      if (n >= 40) fail_count++;
      q = dat_o;
      e = err;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic results;
      if (fail_count == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // Main sequence: walking ones with reserved bits set, then random words
   initial begin
      rnd = 32'h9B2A;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk("pads", pads, exp_pads(8'h00));
      wb(1'b0, `PKC_CTRL_OFFSET, 4'hF, 32'h0);
      chk("reset", q, 0);
      for (int i = 0; i < 24; i++) begin
         rnd = lfsr(rnd);
         v = (i < 8) ? (32'hFFFFFF00 | (32'h1 << i)) : rnd;
         wb(1'b1, `PKC_CTRL_OFFSET, 4'hF, v);
         chk("pads", pads, exp_pads(v[7:0]));
         wb(1'b0, `PKC_CTRL_OFFSET, 4'hF, ~v);
         chk("ctrl", q, {24'h0, v[7:0]});
      end
      // Masked byte and unmapped writes must leave the register alone
      wb(1'b1, `PKC_CTRL_OFFSET, 4'hE, ~v);
      wb(1'b1, 4'h8, 4'hF, ~v);
      chk("err", e, 1'b1);
      wb(1'b0, `PKC_CTRL_OFFSET, 4'hF, 32'h0);
      chk("ctrl", q, {24'h0, v[7:0]});
      wb(1'b0, `PKC_ID_OFFSET, 4'hF, 32'h0);
      chk("id", q, `PKC_ID_VALUE);
      // Mid-run reset must bring every group back to enabled
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk("pads", pads, exp_pads(8'h00));
      wb(1'b0, `PKC_CTRL_OFFSET, 4'hF, 32'h0);
      chk("ctrl", q, 0);
      results();
   end
   // Watchdog: the whole run needs about 4.3 us
   initial begin
      #20us;
      fail_count++;
      results();
   end
endmodule // test_pad_keeper_control
`default_nettype wire
